// ==== hw/supervisor_pkg.sv ====
// Package with timing constants, comparator bit group and state types for the supply supervisor.
package supervisor_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CHECK_PERIOD_MS = 200;
  localparam int unsigned CHECK_PERIOD_CYC = CHECK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CHECK_ON_US = 25;
  localparam int unsigned CHECK_ON_CYC = CHECK_ON_US * CLK_MHZ;
  localparam int unsigned CE_HOLD_US = 15;
  localparam int unsigned CE_HOLD_CYC = CE_HOLD_US * CLK_MHZ;
  localparam int unsigned SYNC_BITS = 6;
  localparam logic [2:0] SYNC_RST = 3'h0;

  typedef enum logic [1:0] {
    CE_OFF,
    CE_ON,
    CE_DRAIN
  } ce_state_e;

  typedef struct packed {
    logic supply_ok;
    logic lowline_ok;
    logic main_above_batt;
    logic batt_ok;
    logic aux_ok;
    logic force_backup;
  } cmp_bits_s;
endpackage

// ==== hw/sync_bank.sv ====
// Two-flop synchroniser bank for asynchronous comparator results.
`timescale 1ns/100ps
module sync_bank #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // sync_bank

// ==== hw/supply_supervisor_ce_gating.sv ====
// Supervisor logic: freshness seal, battery check, chip-enable gating and status outputs.
// Functional notes
// - Sealed cell stays isolated even when backup needed.
// - Seal ends on reset output rising edge.
// - Battery check every 200ms, 25us load window.
// - Checks start only after reset release.
// - Low cell drives battery good low, sticky.
// - Reset released: path opens one cycle later, then passes all transitions.
// - Reset asserted: path off, input high impedance.
// - Input high at reset: disable path immediately.
// - Input low: hold until rise or 15us.
// - Path off: pull output up to backed supply.
// - Aux fail output follows aux comparator with hysteresis.
// - Early warning follows lowline comparator ahead of reset.
// - Backup indicator high exactly while on battery.
// - Reset held while supply below threshold.
// - Return to main deferred until above battery/threshold.
`timescale 1ns/100ps
module supply_supervisor_ce_gating
  import supervisor_pkg::*;
#(
  parameter int unsigned CHECK_PERIOD = CHECK_PERIOD_CYC,
  parameter int unsigned CHECK_ON = CHECK_ON_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic lowline_ok_i,
  input wire logic main_above_batt_i,
  input wire logic batt_ok_i,
  input wire logic aux_monitor_in_i,
  input wire logic force_backup_in_i,
  input wire logic seal_request_i,
  input wire logic delay_done_i,
  input wire logic gated_select_in_i,
  output logic reset_n_o,
  output logic seal_active_o,
  output logic batt_connect_o,
  output logic batt_load_o,
  output logic battery_good_out_o,
  output logic gated_select_out_o,
  output logic gated_select_out_oe_o,
  output logic gated_select_pullup_o,
  output logic gated_select_in_hiz_o,
  output logic aux_fail_out_o,
  output logic lowline_n_o,
  output logic on_backup_indicator_o
);
  cmp_bits_s cmp;
  logic [SYNC_BITS-1:0] cmp_raw;
  logic [SYNC_BITS-1:0] cmp_sync;
  logic reset_n_prev;
  logic on_battery;
  logic [31:0] period_cnt;
  logic [31:0] on_cnt;
  logic [31:0] hold_cnt;
  ce_state_e ce_state;
  logic ce_pass;
  logic next_reset_n;
  logic [31:0] drain_age;

  assign cmp_raw = {supply_ok_i, lowline_ok_i, main_above_batt_i, batt_ok_i,
                    aux_monitor_in_i, force_backup_in_i};

  sync_bank #(.WIDTH(SYNC_BITS)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(cmp_raw),
    .sync_o(cmp_sync)
  );
  assign cmp = cmp_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Reset output is low while the supply is low or the delay has not run.
  assign next_reset_n = cmp.supply_ok & delay_done_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_n_o <= 1'b0;
      reset_n_prev <= 1'b0;
    end else begin
      reset_n_o <= next_reset_n;
      reset_n_prev <= reset_n_o;
    end
  end

  // The seal is taken when requested and released on the reset rising edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seal_active_o <= 1'b0;
    end else if (reset_n_o && !reset_n_prev) begin
      seal_active_o <= 1'b0;
    end else if (seal_request_i) begin
      seal_active_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source selection: battery when below threshold and battery higher, or forced while the supply is above threshold.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_battery <= 1'b0;
    end else if (cmp.force_backup && cmp.supply_ok) begin
      on_battery <= 1'b1;
    end else if (!cmp.supply_ok && !cmp.main_above_batt) begin
      on_battery <= 1'b1;
    end else if (cmp.supply_ok || cmp.main_above_batt) begin
      on_battery <= 1'b0;
    end
  end

  assign on_backup_indicator_o = on_battery;
  assign batt_connect_o = on_battery & ~seal_active_o;

  //////////////////////////////////////////////////////////////////////////////
  // Periodic battery check, running only while reset is released.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_cnt <= '0;
    end else if (!reset_n_o) begin
      period_cnt <= '0;
    end else if (period_cnt == CHECK_PERIOD - 1) begin
      period_cnt <= '0;
    end else begin
      period_cnt <= period_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt <= '0;
      batt_load_o <= 1'b0;
    end else if (!reset_n_o || seal_active_o) begin
      on_cnt <= '0;
      batt_load_o <= 1'b0;
    end else if (period_cnt == CHECK_PERIOD - 1) begin
      on_cnt <= CHECK_ON - 1;
      batt_load_o <= 1'b1;
    end else if (on_cnt != 0) begin
      on_cnt <= on_cnt - 32'h1;
    end else begin
      batt_load_o <= 1'b0;
    end
  end

  // Battery good falls at the end of a failed window and never rises again.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      battery_good_out_o <= 1'b1;
    end else if (batt_load_o && on_cnt == 0 && !cmp.batt_ok) begin
      battery_good_out_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Chip-enable gate state machine.
  // The gate decides on the edge at which reset falls, from the select level seen
  // there, so that neither a glitch nor a late reopen reaches the RAM.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ce_state <= CE_OFF;
      hold_cnt <= '0;
    end else begin
      case (ce_state)
        CE_OFF: begin
          if (reset_n_o && next_reset_n) begin
            ce_state <= CE_ON;
          end
        end
        CE_ON: begin
          if (!next_reset_n) begin
            if (gated_select_in_i) begin
              ce_state <= CE_OFF;
            end else begin
              ce_state <= CE_DRAIN;
              hold_cnt <= CE_HOLD_CYC - 1;
            end
          end
        end
        CE_DRAIN: begin
          if (gated_select_in_i || hold_cnt == 0) begin
            ce_state <= CE_OFF;
          end else begin
            hold_cnt <= hold_cnt - 32'h1;
          end
        end
        default: begin
          ce_state <= CE_OFF;
        end
      endcase
    end
  end

  // Helper for the drain-length check: cycles spent in the drain state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drain_age <= '0;
    end else if (ce_state == CE_DRAIN) begin
      drain_age <= drain_age + 32'h1;
    end else begin
      drain_age <= '0;
    end
  end

  assign ce_pass = (ce_state == CE_ON && reset_n_o) ||
                   (ce_state == CE_DRAIN && !gated_select_in_i);
  assign gated_select_out_oe_o = 1'b1;
  assign gated_select_out_o = ce_pass ? gated_select_in_i : 1'b1;
  assign gated_select_pullup_o = ~ce_pass;
  assign gated_select_in_hiz_o = ~ce_pass;

  //////////////////////////////////////////////////////////////////////////////
  // Status outputs straight from the synchronized comparator bits.
  assign aux_fail_out_o = cmp.aux_ok;
  assign lowline_n_o = cmp.lowline_ok;

  a_seal_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reset_n_o && !reset_n_prev) |=> !seal_active_o)
    else $error("seal not cleared on reset rise");
  a_seal_isolate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    seal_active_o |-> !batt_connect_o)
    else $error("battery connected while sealed");
  a_check_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !reset_n_o |=> !batt_load_o)
    else $error("battery check during reset");
  a_bgood_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !battery_good_out_o |=> !battery_good_out_o)
    else $error("battery good rose again");
  a_ce_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_state == CE_ON && reset_n_o) |-> gated_select_out_o == gated_select_in_i)
    else $error("select not passed");
  a_ce_fast_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ($fell(reset_n_o) && $past(gated_select_in_i) && $past(ce_state == CE_ON))
    |-> gated_select_pullup_o)
    else $error("path not closed at once");
  a_ce_drain_max: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_state == CE_DRAIN) |-> drain_age < CE_HOLD_CYC)
    else $error("drain too long");
  a_ce_pullup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_state == CE_OFF) |-> (gated_select_pullup_o && gated_select_out_o && gated_select_in_hiz_o))
    else $error("pullup missing while disabled");
  a_reset_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cmp.supply_ok |=> !reset_n_o)
    else $error("reset released with supply low");
endmodule // supply_supervisor_ce_gating

// ==== tb/ram_model.sv ====
// Behavioural static RAM that counts selects seen on its chip-enable pin.
`timescale 1ns/100ps
module ram_model (
  input wire logic clk_i,
  input wire logic sel_n_i,
  output int unsigned selects_o
);
  logic last = 1'h1;
  initial selects_o = 0;
  // Each falling edge of the active-low enable starts one access.
  always @(posedge clk_i) begin
    if (last === 1'h1 && sel_n_i === 1'h0) selects_o <= selects_o + 1;
    last <= sel_n_i;
  end
endmodule // ram_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the supply supervisor logic.
`timescale 1ns/100ps
module tb_top;
  import supervisor_pkg::*;
  logic clk_i = 0, rst_n_i = 0, supply_ok_i = 0, lowline_ok_i = 0, main_above_batt_i = 1;
  logic batt_ok_i = 1, aux_monitor_in_i = 1, force_backup_in_i = 0, seal_request_i = 0;
  logic delay_done_i = 0, gated_select_in_i = 1;
  logic reset_n_o, seal_active_o, batt_connect_o, batt_load_o, battery_good_out_o;
  logic gated_select_out_o, gated_select_pullup_o, gated_select_in_hiz_o, gated_select_out_oe_o;
  logic aux_fail_out_o, lowline_n_o, on_backup_indicator_o;
  int num_errors = 0, n_compared = 0, cycles = 0;
  int unsigned selects, sel_base;
  supply_supervisor_ce_gating #(.CHECK_PERIOD(100), .CHECK_ON(5)) i_dut (
    .clk_i, .rst_n_i, .supply_ok_i, .lowline_ok_i, .main_above_batt_i, .batt_ok_i,
    .aux_monitor_in_i, .force_backup_in_i, .seal_request_i, .delay_done_i, .gated_select_in_i,
    .reset_n_o, .seal_active_o, .batt_connect_o, .batt_load_o, .battery_good_out_o,
    .gated_select_out_o, .gated_select_out_oe_o, .gated_select_pullup_o,
    .gated_select_in_hiz_o, .aux_fail_out_o, .lowline_n_o, .on_backup_indicator_o);
  ram_model i_ram (.clk_i(clk_i), .sel_n_i(gated_select_out_o), .selects_o(selects));
  initial forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Waits for the check window (load set) or for the reset output (load clear).
  task automatic wait_lvl(input bit load, input logic v, input int lim);
    while ((load ? batt_load_o : reset_n_o) !== v && lim > 0) begin
      cyc(1);
      lim--;
    end
    chk(load ? batt_load_o : reset_n_o, v, "wait ran out");
  endtask
  task automatic power(input logic on);
    supply_ok_i = on;
    wait_lvl(1'b0, on, 10);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    chk(gated_select_pullup_o, 1'h1, "pullup in reset");
    chk(battery_good_out_o, 1'h1, "battery good reset");
    rst_n_i = 1;
    seal_request_i = 1;
    cyc(1);
    seal_request_i = 0;
    cyc(1);
    chk(seal_active_o, 1'h1, "seal not armed");
    chk(batt_connect_o, 1'h0, "sealed cell connected");
    chk(batt_load_o, 1'h0, "check before release");
    delay_done_i = 1;
    lowline_ok_i = 1;
    power(1);
    cyc(2);
    chk(seal_active_o, 1'h0, "seal kept after reset rise");
    for (int i = 0; i < 2; i++) begin
      gated_select_in_i = i[0];
      cyc(1);
      chk(gated_select_out_o, i[0], "path not passing");
      chk(gated_select_pullup_o, 1'h0, "pullup while enabled");
    end
    chk(gated_select_out_oe_o, 1'h1, "select output not driven");
    wait_lvl(1'b1, 1'h1, 120);
    cyc(4);
    chk(batt_load_o, 1'h1, "window short");
    cyc(1);
    chk(batt_load_o, 1'h0, "window long");
    batt_ok_i = 0;
    cyc(90);
    chk(batt_load_o, 1'h0, "period short");
    wait_lvl(1'b1, 1'h1, 12);
    cyc(6);
    chk(battery_good_out_o, 1'h0, "low cell missed");
    batt_ok_i = 1;
    wait_lvl(1'b1, 1'h1, 110);
    cyc(6);
    chk(battery_good_out_o, 1'h0, "battery good not sticky");
    aux_monitor_in_i = 0;
    force_backup_in_i = 1;
    cyc(4);
    chk(aux_fail_out_o, 1'h0, "aux fail");
    chk(on_backup_indicator_o, 1'h1, "forced backup");
    aux_monitor_in_i = 1;
    force_backup_in_i = 0;
    lowline_ok_i = 0;
    cyc(4);
    chk(aux_fail_out_o, 1'h1, "aux recover");
    chk(on_backup_indicator_o, 1'h0, "back on main");
    chk(lowline_n_o & reset_n_o, 1'h0, "no early warning");
    chk(reset_n_o, 1'h1, "warning not ahead of reset");
    gated_select_in_i = 0;
    main_above_batt_i = 0;
    power(0);
    cyc(3000);
    chk(gated_select_out_o, 1'h0, "write cut short");
    chk(on_backup_indicator_o, 1'h1, "battery indicator");
    cyc(CE_HOLD_CYC - 3001);
    chk(gated_select_out_o, 1'h0, "hold ended early");
    cyc(1);
    chk(gated_select_out_o, 1'h1, "hold not ended");
    gated_select_in_i = 1;
    cyc(1);
    gated_select_in_i = 0;
    cyc(2);
    chk(gated_select_in_hiz_o, 1'h1, "input not released");
    chk(gated_select_out_o, 1'h1, "select passed in reset");
    main_above_batt_i = 1;
    power(1);
    cyc(2);
    chk(on_backup_indicator_o, 1'h0, "stuck on battery");
    sel_base = selects;
    power(0);
    cyc(5);
    chk(gated_select_out_o, 1'h0, "drain closed early");
    gated_select_in_i = 1;
    cyc(1);
    gated_select_in_i = 0;
    cyc(1);
    chk(gated_select_out_o, 1'h1, "drain kept after rise");
    power(1);
    cyc(2);
    gated_select_in_i = 1;
    cyc(1);
    power(0);
    chk(gated_select_pullup_o, 1'h1, "high input not cut");
    gated_select_in_i = 0;
    cyc(3);
    chk(selects - sel_base == 1, 1'h1, "RAM selected in reset");
    finish_test();
  end
endmodule // tb_top
